//--- hw/tcm_pkg.sv
// Shared constants, register map and types of the timer/clock mode control
package tcm_pkg;
	// Clock rate and timing figures
	localparam int CLK_HZ = 40_000_000;
	localparam int SEC_CYC = CLK_HZ;
	localparam int SUPPLY_LOSS_MS = 30;
	localparam int SUPPLY_LOSS_CYC = SUPPLY_LOSS_MS * (CLK_HZ / 1000);
	localparam int LAMP_TEST_MS = 1000;
	localparam int LAMP_CYC = LAMP_TEST_MS * (CLK_HZ / 1000);
	localparam int SW_CW = 24;
	// Register indices on the plain port
	localparam logic [3:0] A_CONFIG = 4'h0;
	localparam logic [3:0] A_SYNC_TIME = 4'h1;
	localparam logic [3:0] A_TIME = 4'h2;
	localparam logic [3:0] A_CODE_STORE = 4'h3;
	localparam logic [3:0] A_CODE_ENTRY = 4'h4;
	localparam logic [3:0] A_TARGET = 4'h5;
	localparam logic [3:0] A_STATUS = 4'h6;
	localparam logic [3:0] A_COUNT = 4'h7;
	// Indices 8..15 hold output times: 8..11 output 1, 12..15 output 2
	localparam int A_TIMES_BIT = 3;
	// Configuration field positions
	localparam int CFG_FUNC = 0;
	localparam int CFG_FMT24 = 1;
	localparam int CFG_UP = 2;
	localparam int CFG_LRP = 3;
	localparam int CFG_OUT1_EN = 8;
	localparam int CFG_OUT1_TWICE = 9;
	localparam int CFG_OUT2_EN = 10;
	localparam int CFG_OUT2_TWICE = 11;
	// Bits 7:4 hold input, start/stop and cycle settings
	localparam logic [15:0] CFG_HALT_MASK = 16'h0FF4;
	localparam logic [15:0] CFG_RST = 16'h0004;
	localparam logic [15:0] CODE_RST = 16'h0000;
	localparam logic [15:0] CODE_OPEN = 16'h0000;
	// Time-of-day limits and 12-hour conversion
	localparam logic [5:0] SS_MAX = 6'h3B;
	localparam logic [5:0] MM_MAX = 6'h3B;
	localparam logic [4:0] HH_MAX = 5'h17;
	localparam logic [4:0] HH_NOON = 5'h0C;
	typedef struct packed {
		logic [4:0] hh;
		logic [5:0] mm;
		logic [5:0] ss;
	} tcm_tod_s;
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} tcm_bus_s;
	typedef enum logic [2:0] {SW_IDLE, SW_READY, SW_RUN, SW_PAUSE, SW_DONE, SW_HALT} tcm_sw_e;
	typedef enum logic {PW_LAMP, PW_RUN} tcm_pw_e;
endpackage

//--- hw/tcm_tick.sv
// Divider that yields a one-cycle enable pulse every DIV clock cycles
`timescale 1ns/1ps
`default_nettype none
module tcm_tick #(
	parameter int DIV = 40
) (
	input wire logic clk, // System clock
	input wire logic rst, // Asynchronous reset, active high
	input wire logic clr, // Restart the period
	output logic tick_q // One-cycle pulse per period
);
	localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [W-1:0] LAST = W'(DIV - 1);
	logic [W-1:0] cnt_q;

	if (DIV < 2)
	begin : g_chk
		$error("tcm_tick: DIV must be at least 2");
	end

	// Free-running count, restarted on clr so a new time gets a full second
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end
		else if (clr)
		begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end
		else if (cnt_q == LAST)
		begin
			cnt_q <= '0;
			tick_q <= 1'b1;
		end
		else
		begin
			cnt_q <= cnt_q + 1'b1;
			tick_q <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- hw/tcm_out_sched.sv
// One switched output with two on and two off times per day
`timescale 1ns/1ps
`default_nettype none
module tcm_out_sched
	import tcm_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic rst, // Asynchronous reset, active high
	input wire logic live, // Time of day is valid and running
	input wire tcm_tod_s now, // Current time of day
	input wire logic en, // Output enable setting
	input wire logic twice, // Use second on/off pair
	input wire tcm_tod_s [3:0] times, // on1, off1, on2, off2
	output logic out_q // Output closed when high
);
	// Matching is level based; a time jumped over by a set is missed
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			out_q <= 1'b0;
		else if (!en)
			out_q <= 1'b0;
		else if (live)
		begin
			if (now == times[0])
				out_q <= 1'b1;
			else if (now == times[1])
				out_q <= 1'b0;
			else if (twice && now == times[2])
				out_q <= 1'b1;
			else if (twice && now == times[3])
				out_q <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- hw/tcm_top.sv
// Timer / time-of-day clock mode control with register port
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Run as stopwatch or time-of-day clock
// - Clock shows twelve or twenty-four hour format
// - Time adjust needs matching four-digit code
// - Closed sync contacts hold sync time in clock function
// - Each output switches twice per day
// - Power-up lights all segments, then runs
// - Clock flashes, idle until time set
// - Supply loss over 30 ms unsets clock
// - Stopwatch needs reset before starting
// - Stopwatch refuses start with zero target
// - Key setting change forces fail-safe halt
// - Outputs inactive unless enabled
// - Wrong code refuses configuration access
module tcm_top
	import tcm_pkg::*;
#(
	parameter int SEC_DIV = SEC_CYC,
	parameter int LOSS_CYC = SUPPLY_LOSS_CYC,
	parameter int LAMP_DIV = LAMP_CYC,
	parameter int CW = SW_CW
) (
	input wire logic clk, // 40 MHz system clock
	input wire logic rst, // Asynchronous reset, active high (power-up)
	input wire tcm_bus_s bus, // Register port: addr, wdata, wr, rd
	output logic [31:0] rd_data_q, // Read data, cycle after rd
	input wire logic sync_link, // Sync terminals a and b linked
	input wire logic supply_ok, // Supply present
	input wire logic start_level, // Stopwatch start/stop level
	input wire logic reset_combo, // Front-panel reset button combination
	output logic lamp_test_q, // All segments lit
	output logic time_flash_q, // Display flashing, time unset
	output tcm_tod_s disp_q, // Displayed time, hours in format
	output logic disp_pm_q, // Afternoon in 12-hour format
	output logic sync_hold_q, // Clock held by sync contacts
	output logic [CW-1:0] sw_count_q, // Stopwatch seconds
	output logic sw_running_q, // Stopwatch running
	output logic failsafe_halt_q, // Stopwatch in fail-safe halt
	output logic ctl_out1_q, // Control output 1
	output logic ctl_out2_q // Control output 2
);
	localparam int LW = $clog2(LOSS_CYC + 1);
	localparam int PW = $clog2(LAMP_DIV + 1);
	localparam logic [LW-1:0] LOSS_LAST = LW'(LOSS_CYC);
	localparam logic [PW-1:0] LAMP_LAST = PW'(LAMP_DIV - 1);

	if (SEC_DIV < 2 || LOSS_CYC < 1 || LAMP_DIV < 2 || CW < 2 || CW > 32)
	begin : g_chk
		$error("tcm_top: parameter out of range");
	end

	logic [15:0] cfg_q;
	logic [15:0] code_q;
	logic unlocked_q;
	tcm_tod_s sync_q;
	tcm_tod_s tod_q;
	logic time_set_q;
	logic [CW-1:0] target_q;
	tcm_tod_s [7:0] times_q;
	tcm_sw_e sw_q;
	tcm_pw_e pw_q;
	logic [LW-1:0] loss_cnt_q;
	logic [PW-1:0] lamp_cnt_q;
	logic sec_tick;
	logic access_ok;
	logic func_tod;
	logic running;
	logic loss_trip;
	logic time_wr;
	logic cfg_wr;
	logic halt_req;
	logic sw_reset;
	logic up;
	logic tod_live;

	// Access control and decoded writes
	assign access_ok = unlocked_q || (code_q == CODE_OPEN);
	assign func_tod = cfg_q[CFG_FUNC];
	assign up = cfg_q[CFG_UP];
	assign running = (pw_q == PW_RUN);
	assign cfg_wr = bus.wr && bus.addr == A_CONFIG && access_ok;
	assign time_wr = bus.wr && bus.addr == A_TIME && access_ok && running;
	assign tod_live = running && func_tod && time_set_q && !sync_link;
	// A write that alters key stopwatch settings trips the fail-safe halt
	assign halt_req = cfg_wr && !func_tod &&
		(((bus.wdata[15:0] ^ cfg_q) & CFG_HALT_MASK) != 16'h0000);
	// Linked sync terminals act as the external reset in stopwatch mode
	assign sw_reset = sync_link || (reset_combo && cfg_q[CFG_LRP]);
	assign loss_trip = !supply_ok && (loss_cnt_q == LOSS_LAST);

	// Time-of-day step: seconds, minutes, hours, wrap at midnight
	function automatic tcm_tod_s tod_inc(input tcm_tod_s t);
		tcm_tod_s n;
		n = t;
		if (t.ss == SS_MAX)
		begin
			n.ss = 6'h00;
			if (t.mm == MM_MAX)
			begin
				n.mm = 6'h00;
				n.hh = (t.hh == HH_MAX) ? 5'h00 : 5'(t.hh + 5'h01);
			end
			else
				n.mm = 6'(t.mm + 6'h01);
		end
		else
			n.ss = 6'(t.ss + 6'h01);
		return n;
	endfunction

	// Second enable, restarted when time is loaded so it counts whole seconds
	tcm_tick #(
		.DIV(SEC_DIV)
	) u_sec (
		.clk(clk),
		.rst(rst),
		.clr(time_wr || sync_link),
		.tick_q(sec_tick)
	);

	// Power-up lamp test, then run on the retained configuration
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pw_q <= PW_LAMP;
			lamp_cnt_q <= '0;
		end
		else if (pw_q == PW_LAMP)
		begin
			if (lamp_cnt_q == LAMP_LAST)
				pw_q <= PW_RUN;
			else
				lamp_cnt_q <= lamp_cnt_q + 1'b1;
		end
	end

	// Supply-loss timer; short dips under the limit are ridden through
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			loss_cnt_q <= '0;
		else if (supply_ok)
			loss_cnt_q <= '0;
		else if (loss_cnt_q != LOSS_LAST)
			loss_cnt_q <= loss_cnt_q + 1'b1;
	end

	// Configuration store; reset values stand for the retained settings
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cfg_q <= CFG_RST;
			code_q <= CODE_RST;
			sync_q <= '0;
			target_q <= '0;
			times_q <= '0;
		end
		else if (bus.wr && access_ok)
		begin
			case (bus.addr)
				A_CONFIG: cfg_q <= bus.wdata[15:0];
				A_SYNC_TIME: sync_q <= bus.wdata[16:0];
				A_CODE_STORE: code_q <= bus.wdata[15:0];
				A_TARGET: target_q <= bus.wdata[CW-1:0];
				default:
				begin
					if (bus.addr[A_TIMES_BIT])
						times_q[bus.addr[2:0]] <= bus.wdata[16:0];
				end
			endcase
		end
	end

	// Code entry: a match unlocks, any mismatch locks again
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			unlocked_q <= 1'b0;
		else if (bus.wr && bus.addr == A_CODE_ENTRY)
			unlocked_q <= (bus.wdata[15:0] == code_q);
	end

	// Time of day: hold at sync time while linked, then resume from it
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tod_q <= '0;
			time_set_q <= 1'b0;
			sync_hold_q <= 1'b0;
		end
		else if (running)
		begin
			sync_hold_q <= func_tod && sync_link;
			if (loss_trip)
				time_set_q <= 1'b0;
			else if (func_tod && sync_link)
				tod_q <= sync_q;
			else if (sync_hold_q)
				time_set_q <= 1'b1;
			else if (time_wr)
			begin
				tod_q <= bus.wdata[16:0];
				time_set_q <= 1'b1;
			end
			else if (tod_live && sec_tick)
				tod_q <= tod_inc(tod_q);
		end
	end

	// Stopwatch: reset arms it, halt freezes at end-of-count
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sw_q <= SW_IDLE;
			sw_count_q <= '0;
		end
		else if (func_tod || !running)
			sw_q <= SW_IDLE;
		else if (halt_req)
		begin
			sw_q <= SW_HALT;
			sw_count_q <= up ? target_q : '0;
		end
		else if (sw_reset)
		begin
			sw_q <= SW_READY;
			sw_count_q <= up ? '0 : target_q;
		end
		else
		begin
			case (sw_q)
				SW_READY, SW_PAUSE:
				begin
					if (start_level && target_q != '0)
						sw_q <= SW_RUN;
				end
				SW_RUN:
				begin
					if (!start_level)
						sw_q <= SW_PAUSE;
					else if (sec_tick)
					begin
						if (up)
						begin
							sw_count_q <= sw_count_q + 1'b1;
							if (sw_count_q + 1'b1 == target_q)
								sw_q <= SW_DONE;
						end
						else
						begin
							sw_count_q <= sw_count_q - 1'b1;
							if (sw_count_q == {{(CW-1){1'b0}}, 1'b1})
								sw_q <= SW_DONE;
						end
					end
				end
				// Done leaves only through a reset, a halt request or clock function, idle through a reset or a halt request, halt through a reset or clock function
				default: sw_q <= sw_q;
			endcase
		end
	end

	// Display: 12-hour conversion and flashing while unset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			disp_q <= '0;
			disp_pm_q <= 1'b0;
			time_flash_q <= 1'b0;
			lamp_test_q <= 1'b1;
			sw_running_q <= 1'b0;
			failsafe_halt_q <= 1'b0;
		end
		else
		begin
			lamp_test_q <= !running;
			time_flash_q <= running && func_tod && !time_set_q;
			sw_running_q <= (sw_q == SW_RUN);
			failsafe_halt_q <= (sw_q == SW_HALT);
			disp_q.mm <= tod_q.mm;
			disp_q.ss <= tod_q.ss;
			if (cfg_q[CFG_FMT24])
			begin
				disp_q.hh <= tod_q.hh;
				disp_pm_q <= 1'b0;
			end
			else
			begin
				disp_pm_q <= (tod_q.hh >= HH_NOON);
				if (tod_q.hh == 5'h00)
					disp_q.hh <= HH_NOON;
				else if (tod_q.hh > HH_NOON)
					disp_q.hh <= 5'(tod_q.hh - HH_NOON);
				else
					disp_q.hh <= tod_q.hh;
			end
		end
	end

	// Switched outputs follow the day only in clock function
	tcm_out_sched u_out1 (
		.clk(clk),
		.rst(rst),
		.live(tod_live),
		.now(tod_q),
		.en(func_tod && cfg_q[CFG_OUT1_EN]),
		.twice(cfg_q[CFG_OUT1_TWICE]),
		.times(times_q[3:0]),
		.out_q(ctl_out1_q)
	);

	tcm_out_sched u_out2 (
		.clk(clk),
		.rst(rst),
		.live(tod_live),
		.now(tod_q),
		.en(func_tod && cfg_q[CFG_OUT2_EN]),
		.twice(cfg_q[CFG_OUT2_TWICE]),
		.times(times_q[7:4]),
		.out_q(ctl_out2_q)
	);

	// Read port, data in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rd_data_q <= 32'h00000000;
		else if (bus.rd)
		begin
			rd_data_q <= 32'h00000000;
			case (bus.addr)
				A_CONFIG: rd_data_q[15:0] <= cfg_q;
				A_SYNC_TIME: rd_data_q[16:0] <= sync_q;
				A_TIME: rd_data_q[16:0] <= tod_q;
				A_CODE_ENTRY: rd_data_q[0] <= access_ok;
				A_TARGET: rd_data_q[CW-1:0] <= target_q;
				A_STATUS: rd_data_q[7:0] <= {sync_hold_q, !running, access_ok,
					time_set_q, 1'b0, sw_q};
				A_COUNT: rd_data_q[CW-1:0] <= sw_count_q;
				default:
				begin
					// The stored code is write-only so it cannot be read back
					if (bus.addr[A_TIMES_BIT])
						rd_data_q[16:0] <= times_q[bus.addr[2:0]];
				end
			endcase
		end
	end
endmodule
`default_nettype wire

//--- dv/tcm_panel_model.sv
// Model of the front-panel buttons and sync contacts
`timescale 1ns/1ps
`default_nettype none
module tcm_panel_model (
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire logic slow, // Answer two cycles late
	input wire logic [2:0] cmd, // Sync, combo, start
	output logic sync_link, // Terminals linked
	output logic reset_combo, // Combination held
	output logic start_level // Start switch
);
	logic [2:0] d1_q;
	logic [2:0] d2_q;
	// Contacts settle one or two cycles after the operator acts
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			d1_q <= 3'h0;
			d2_q <= 3'h0;
		end
		else
		begin
			d1_q <= cmd;
			d2_q <= d1_q;
		end
	end
	assign {sync_link, reset_combo, start_level} = slow ? d2_q : d1_q;
endmodule
`default_nettype wire

//--- dv/tcm_top_chk.sv
// Port checker for the timer/clock mode control
`timescale 1ns/1ps
`default_nettype none
module tcm_top_chk
	import tcm_pkg::*;
#(
	parameter int CW = SW_CW
) (
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire tcm_bus_s bus, // Register port
	input wire logic start_level, // Start
	input wire logic sync_link, // Sync contact
	input wire logic lamp_test_q, // Lamp
	input wire logic time_flash_q, // Flash
	input wire tcm_tod_s disp_q, // Display
	input wire logic sync_hold_q, // Sync hold
	input wire logic [CW-1:0] sw_count_q, // Count
	input wire logic sw_running_q, // Running
	input wire logic failsafe_halt_q, // Halt
	input wire logic ctl_out1_q // Output 1
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// Display, stopwatch and output relations; the display lags the count by a cycle
	property p_lamp;
		$fell(rst) |-> lamp_test_q;
	endproperty
	a_lamp: assert property (p_lamp) else $error("lamp off at start");
	property p_dark;
		lamp_test_q |-> !sw_running_q && !ctl_out1_q;
	endproperty
	a_dark: assert property (p_dark) else $error("active in lamp test");
	property p_hold;
		sync_hold_q |-> $past(sync_link);
	endproperty
	a_hold: assert property (p_hold) else $error("hold without link");
	property p_still;
		sync_hold_q && $past(sync_hold_q) && $past(sync_hold_q, 2) |-> $stable(disp_q);
	endproperty
	a_still: assert property (p_still) else $error("time moved in hold");
	property p_halt;
		failsafe_halt_q |-> !sw_running_q;
	endproperty
	a_halt: assert property (p_halt) else $error("running in halt");
	// The halt flag lags the state by a cycle, so compare the count one cycle back
	property p_frozen;
		failsafe_halt_q && $past(failsafe_halt_q) |-> $past(sw_count_q) == $past(sw_count_q, 2);
	endproperty
	a_frozen: assert property (p_frozen) else $error("count moved in halt");
	property p_flash;
		time_flash_q && $past(time_flash_q) && !$past(sync_link) && !$past(sync_link, 2)
			&& !$past(bus.wr) && !$past(bus.wr, 2) |-> $stable(disp_q);
	endproperty
	a_flash: assert property (p_flash) else $error("unset clock counts");
	property p_run;
		$rose(sw_running_q) |-> $past(start_level, 2) && !$past(failsafe_halt_q);
	endproperty
	a_run: assert property (p_run) else $error("bad start");
endmodule
bind tcm_top tcm_top_chk #(.CW(CW)) u_chk (.clk, .rst, .bus, .start_level, .sync_link,
	.lamp_test_q, .time_flash_q, .disp_q, .sync_hold_q, .sw_count_q, .sw_running_q,
	.failsafe_halt_q, .ctl_out1_q);
`default_nettype wire

//--- dv/tcm_top_tb.sv
// Self-checking bench for the timer/clock mode control
`timescale 1ns/1ps
`default_nettype none
module tcm_top_tb
	import tcm_pkg::*;
;
	typedef struct {logic [3:0] a; logic [31:0] e;} tcm_row_s;
	logic clk;
	logic rst;
	tcm_bus_s bus;
	logic [31:0] rd_data_q;
	logic supply_ok;
	logic slow;
	logic [2:0] cmd;
	logic sync_link;
	logic reset_combo;
	logic start_level;
	logic lamp_test_q;
	logic time_flash_q;
	tcm_tod_s disp_q;
	logic disp_pm_q;
	logic sync_hold_q;
	logic [23:0] sw_count_q;
	logic sw_running_q;
	logic failsafe_halt_q;
	logic ctl_out1_q;
	logic ctl_out2_q;
	int bad_count;
	int tests_run;
	logic [31:0] v;
	// Reset values seen after the lamp phase, stopwatch idle and open code
	tcm_row_s rows[6] = '{'{A_CONFIG, 32'h4}, '{A_CODE_STORE, 32'h0}, '{A_CODE_ENTRY, 32'h1},
		'{A_TARGET, 32'h0}, '{A_STATUS, 32'h20}, '{A_COUNT, 32'h0}};
	// Short counts keep the run brief
	tcm_top #(.SEC_DIV(8), .LOSS_CYC(20), .LAMP_DIV(4)) u_dut (.clk, .rst, .bus, .rd_data_q,
		.sync_link, .supply_ok, .start_level, .reset_combo, .lamp_test_q, .time_flash_q,
		.disp_q, .disp_pm_q, .sync_hold_q, .sw_count_q, .sw_running_q, .failsafe_halt_q,
		.ctl_out1_q, .ctl_out2_q);
	tcm_panel_model u_pan (.clk, .rst, .slow, .cmd, .sync_link, .reset_combo, .start_level);
	// 40 MHz clock
	initial
	begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	// Read data appears in the cycle after the strobe and holds until the next read
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 v = rd_data_q;
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pan(input logic [2:0] c);
		@(posedge clk);
		cmd <= c;
	endtask
	task automatic loss(input int n);
		@(posedge clk);
		supply_ok <= 0;
		repeat (n) @(posedge clk);
		supply_ok <= 1;
		cy(2);
	endtask
	task automatic wo(input logic x);
		repeat (40)
		begin
			@(posedge clk);
			#1;
			if (ctl_out1_q === x)
				break;
		end
	endtask
	function automatic logic [31:0] t(input logic [4:0] h, input logic [5:0] m, input logic [5:0] s);
		return {15'h0, h, m, s};
	endfunction
	// Main sequence
	initial
	begin
		rst = 1;
		bus = '{4'h0, 32'h0, 1'b0, 1'b0};
		supply_ok = 1;
		slow = 0;
		cmd = 3'h0;
		bad_count = 0;
		tests_run = 0;
		repeat (3) @(posedge clk);
		#1 chk(lamp_test_q, 1);
		chk(sw_running_q, 0);
		@(posedge clk);
		rst <= 0;
		cy(6);
		chk(lamp_test_q, 0);
		foreach (rows[i])
		begin
			rd(rows[i].a);
			chk(v, rows[i].e);
		end
		// Start with combination but no permit, then sync-link reset with zero target
		pan(3'b011);
		cy(4);
		chk(sw_running_q, 0);
		pan(3'b101);
		pan(3'b001);
		cy(4);
		chk(sw_running_q, 0);
		wr(A_TARGET, 3);
		cy(2);
		chk(sw_running_q, 1);
		cy(30);
		chk(sw_count_q, 3);
		chk(sw_running_q, 0);
		// Permitted local reset with a slow panel, then halt in mid-run
		slow <= 1;
		wr(A_CONFIG, 32'h000C);
		pan(3'b010);
		pan(3'b001);
		cy(6);
		chk(sw_running_q, 1);
		wr(A_CONFIG, 32'h001C);
		cy(2);
		chk(failsafe_halt_q, 1);
		chk(sw_count_q, 3);
		cy(10);
		chk(sw_running_q, 0);
		pan(3'b010);
		cy(5);
		chk(failsafe_halt_q, 0);
		rd(A_STATUS);
		chk(v[2:0], 1);
		// Security code
		wr(A_CODE_STORE, 32'h1234);
		wr(A_CODE_ENTRY, 32'h1111);
		rd(A_CODE_ENTRY);
		chk(v[0], 0);
		wr(A_TARGET, 9);
		rd(A_TARGET);
		chk(v, 3);
		wr(A_CODE_ENTRY, 32'h1234);
		rd(A_CODE_ENTRY);
		chk(v[0], 1);
		// Clock function
		pan(3'b000);
		wr(A_CONFIG, 32'h0003);
		cy(24);
		chk(time_flash_q, 1);
		chk(sw_running_q, 0);
		wr(A_TIME, t(23, 59, 58));
		cy(2);
		chk(disp_q, t(23, 59, 58));
		chk(time_flash_q, 0);
		cy(17);
		chk(disp_q, t(0, 0, 0));
		wr(A_CONFIG, 32'h0001);
		cy(2);
		chk(disp_q.hh, 12);
		chk(disp_pm_q, 0);
		wr(A_TIME, t(13, 0, 0));
		cy(2);
		chk(disp_q.hh, 1);
		chk(disp_pm_q, 1);
		wr(A_CODE_ENTRY, 0);
		wr(A_TIME, t(5, 0, 0));
		cy(2);
		chk(disp_q.hh, 1);
		wr(A_CODE_ENTRY, 32'h1234);
		// Sync contacts hold and release
		wr(A_SYNC_TIME, t(5, 0, 0));
		pan(3'b100);
		cy(12);
		chk(disp_q, t(5, 0, 0));
		chk(sync_hold_q, 1);
		pan(3'b000);
		cy(14);
		chk(disp_q, t(5, 0, 1));
		loss(10);
		chk(time_flash_q, 0);
		loss(25);
		chk(time_flash_q, 1);
		// Output 1 twice per day, output 2 left disabled on the same times
		wr(4'h8, t(1, 0, 1));
		wr(4'h9, t(1, 0, 2));
		wr(4'hA, t(1, 0, 3));
		wr(4'hB, t(1, 0, 4));
		wr(4'hC, t(1, 0, 1));
		wr(4'hD, t(1, 0, 2));
		wr(A_CONFIG, 32'h0301);
		wr(A_TIME, t(1, 0, 0));
		wo(1);
		chk(ctl_out1_q, 1);
		chk(ctl_out2_q, 0);
		wo(0);
		chk(ctl_out1_q, 0);
		wo(1);
		chk(ctl_out1_q, 1);
		wo(0);
		chk(ctl_out1_q, 0);
		print_verdict;
	end
	// Watchdog well beyond the expected run
	initial
	begin
		#125000;
		bad_count++;
		print_verdict;
	end
endmodule
`default_nettype wire
